// file: hw/ipc_exc_if.sv
// control and drive signals between the block and its excitation driver
`timescale 1ns/1ps
`default_nettype none
interface ipc_exc_if;
  logic       run;
  logic       four_wire;
  logic       connect;
  logic       out_en;
  logic [7:0] delay;
  logic [3:0] gpio;
  logic [3:0] gpio_oe;
  logic       phase_b;
  modport ctl (output run, four_wire, connect, out_en, delay,
               input gpio, gpio_oe, phase_b);
  modport exc (input run, four_wire, connect, out_en, delay,
               output gpio, gpio_oe, phase_b);
endinterface : ipc_exc_if
`default_nettype wire

// file: hw/ipc_excite.sv
// alternating bridge excitation driver for the gpio pins
`timescale 1ns/1ps
`default_nettype none
module ipc_excite
  import ipc_pkg::*;
#(
  parameter int unsigned PHASE_CYCLES = 64
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  ipc_exc_if.exc    exc
);
  // phase counter is eight bits wide
  if (PHASE_CYCLES < 1 || PHASE_CYCLES > 255) begin : g_bad_phase
    $error("ipc_excite: PHASE_CYCLES out of range");
  end

  localparam logic [7:0] PHASE_LEN = 8'(PHASE_CYCLES - 1);

  typedef struct packed {
    ipc_ex_state_t st;
    logic [7:0]    cnt;
    logic          go_b;
  } ipc_ex_t;

  ipc_ex_t cur;
  ipc_ex_t next_cur;

  always_comb begin
    next_cur = cur;
    if (!exc.run) begin
      next_cur.st   = IPC_EX_IDLE;
      next_cur.cnt  = 8'h00;
      next_cur.go_b = 1'b0;
    end else begin
      unique case (cur.st)
        IPC_EX_IDLE: begin
          next_cur.st  = IPC_EX_DRV_A;
          next_cur.cnt = PHASE_LEN;
        end
        IPC_EX_DRV_A, IPC_EX_DRV_B: begin
          if (cur.cnt == 8'h00) begin
            // break before make keeps both bridge legs off for a while
            next_cur.st   = IPC_EX_GAP;
            next_cur.cnt  = exc.delay;
            next_cur.go_b = (cur.st == IPC_EX_DRV_A);
          end else begin
            next_cur.cnt = cur.cnt - 8'h01;
          end
        end
        IPC_EX_GAP: begin
          if (cur.cnt == 8'h00) begin
            next_cur.st  = cur.go_b ? IPC_EX_DRV_B : IPC_EX_DRV_A;
            next_cur.cnt = PHASE_LEN;
          end else begin
            next_cur.cnt = cur.cnt - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur <= '{st: IPC_EX_IDLE, cnt: 8'h00, go_b: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  logic [3:0] drive;
  always_comb begin
    drive = 4'h0;
    if (cur.st == IPC_EX_DRV_A) begin
      drive = exc.four_wire ? 4'b0101 : 4'b0001;
    end else if (cur.st == IPC_EX_DRV_B) begin
      drive = exc.four_wire ? 4'b1010 : 4'b0010;
    end
  end

  assign exc.gpio    = drive;
  assign exc.gpio_oe = (exc.out_en && exc.connect) ? 4'hf : 4'h0;
  assign exc.phase_b = (cur.st == IPC_EX_DRV_B);

  a_gpio_quiet: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !exc.out_en |-> exc.gpio_oe == 4'h0)
    else $error("gpio driven while outputs disabled");
  a_phase_start: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (exc.run && cur.st == IPC_EX_IDLE) |=> cur.st == IPC_EX_DRV_A)
    else $error("excitation did not start in phase a");
endmodule : ipc_excite
`default_nettype wire

// file: hw/ipc_input_path.sv
// input path configuration registers and optional digital pin handling
`timescale 1ns/1ps
`default_nettype none
module ipc_input_path
  import ipc_pkg::*;
#(
  parameter int unsigned PHASE_CYCLES = 64
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cs_n,
  input  wire logic       i_ext_clock_input,
  input  wire logic       i_start,
  input  wire logic       i_reset_pin_n,
  input  wire logic       i_power_down_pin_n,
  input  wire logic       i_cmd_valid,
  input  wire logic [2:0] i_cmd,
  input  wire logic       i_result_valid,
  input  wire logic [7:0] i_result,
  input  wire logic       i_sdo_busy,
  input  wire logic       i_sdo_bit,
  output logic            o_serial_out_done_pin,
  output logic            o_serial_out_done_oe,
  output logic            o_conversion_done_pin_n,
  output logic            o_amp_skip,
  output logic      [2:0] o_gain_code,
  output logic      [3:0] o_pos_input_select,
  output logic      [3:0] o_neg_input_select,
  output logic            o_use_int_osc,
  output logic            o_convert,
  output logic            o_power_down,
  output logic      [3:0] o_gpio,
  output logic      [3:0] o_gpio_oe
);
  // excitation phase counter is eight bits wide
  if (PHASE_CYCLES < 1 || PHASE_CYCLES > 255) begin : g_bad_phase
    $error("ipc_input_path: PHASE_CYCLES out of range");
  end

  // true for a selector code that maps to a real connection
  function automatic logic ipc_sel_ok(input logic [3:0] code);
    ipc_sel_ok = (code >= IPC_SEL_ANALOG_INPUT_0 && code <= IPC_SEL_ANALOG_INPUT_5) ||
                 code == IPC_SEL_TEMP || code == IPC_SEL_OPEN ||
                 code == IPC_SEL_COM;
  endfunction : ipc_sel_ok

  function automatic logic ipc_gain_ok(input logic [2:0] code);
    ipc_gain_ok = code == IPC_GAIN_1 || code == IPC_GAIN_64 ||
                  code == IPC_GAIN_128;
  endfunction : ipc_gain_ok

  typedef struct packed {
    logic [7:0] amp;
    logic [7:0] sel;
    logic [7:0] ctrl;
    logic [7:0] delay;
    logic [7:0] result;
    logic       conversion_done_pin;
    logic       cmd_run;
    logic       pd;
    logic [1:0] sync_cs;
    logic [2:0] sync_clk;
    logic [1:0] sync_start;
    logic [1:0] sync_rst;
    logic [1:0] sync_pd;
    logic [7:0] clk_idle;
    logic [7:0] rdata;
  } ipc_state_t;

  localparam ipc_state_t IPC_STATE_RST = '{
    amp:        IPC_AMP_RST,
    sel:        IPC_SEL_RST,
    ctrl:       IPC_CTRL_RST,
    delay:      IPC_DELAY_RST,
    result:     8'h00,
    conversion_done_pin:       1'b0,
    cmd_run:    1'b0,
    pd:         1'b0,
    sync_cs:    2'b11,
    sync_clk:   3'b000,
    sync_start: 2'b00,
    sync_rst:   2'b11,
    sync_pd:    2'b11,
    clk_idle:   8'h00,
    rdata:      8'h00
  };

  ipc_state_t st;
  ipc_state_t next_st;

  logic cmd_start;
  logic cmd_stop;
  logic cmd_reset;
  logic cmd_pdown;
  logic cmd_wake;
  logic soft_rst;
  logic pd_eff;
  logic converting;
  logic sel_bad;
  logic ext_edge;
  logic [7:0] status;

  assign cmd_start = i_cmd_valid && i_cmd == IPC_CMD_START;
  assign cmd_stop  = i_cmd_valid && i_cmd == IPC_CMD_STOP;
  assign cmd_reset = i_cmd_valid && i_cmd == IPC_CMD_RESET;
  assign cmd_pdown = i_cmd_valid && i_cmd == IPC_CMD_PDOWN;
  assign cmd_wake  = i_cmd_valid && i_cmd == IPC_CMD_WAKE;

  // pin reset is level sensitive and held for as long as the pin is low
  assign soft_rst = cmd_reset || !st.sync_rst[1];
  assign pd_eff   = st.pd || !st.sync_pd[1];

  // start pin only free-runs in continuous mode; commands work in either mode; power-down blocks both
  assign converting = !pd_eff && (st.cmd_run ||
                      (st.sync_start[1] && st.ctrl[IPC_CTRL_CONT]));

  assign sel_bad = !ipc_sel_ok(st.sel[IPC_POS_LSB +: 4]) ||
                   !ipc_sel_ok(st.sel[IPC_NEG_LSB +: 4]);
  assign ext_edge = st.sync_clk[2] != st.sync_clk[1];

  always_comb begin
    status = 8'h00;
    status[IPC_STAT_CONVERSION_DONE_PIN]    = st.conversion_done_pin;
    status[IPC_STAT_CONV]    = converting;
    status[IPC_STAT_PD]      = pd_eff;
    status[IPC_STAT_INTOSC]  = o_use_int_osc;
    status[IPC_STAT_SELBAD]  = sel_bad;
    status[IPC_STAT_GAINBAD] = !ipc_gain_ok(st.amp[IPC_GAIN_LSB +: 3]);
  end

  always_comb begin
    next_st = st;
    next_st.sync_cs    = {st.sync_cs[0], i_cs_n};
    next_st.sync_clk   = {st.sync_clk[1:0], i_ext_clock_input};
    next_st.sync_start = {st.sync_start[0], i_start};
    next_st.sync_rst   = {st.sync_rst[0], i_reset_pin_n};
    next_st.sync_pd    = {st.sync_pd[0], i_power_down_pin_n};

    // a held-low clock pin stops producing edges and times out
    if (ext_edge) begin
      next_st.clk_idle = 8'h00;
    end else if (st.clk_idle != IPC_CLK_IDLE_CYC) begin
      next_st.clk_idle = st.clk_idle + 8'h01;
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        IPC_ADDR_AMP:    next_st.rdata = st.amp;
        IPC_ADDR_SEL:    next_st.rdata = st.sel;
        IPC_ADDR_CTRL:   next_st.rdata = st.ctrl;
        IPC_ADDR_STAT:   next_st.rdata = status;
        IPC_ADDR_RESULT: next_st.rdata = st.result;
        IPC_ADDR_DELAY:  next_st.rdata = st.delay;
        default:         next_st.rdata = 8'h00;
      endcase
    end

    if (i_wr) begin
      unique case (i_addr)
        // reserved amp bits are stored as written; host keeps them zero
        IPC_ADDR_AMP:   next_st.amp   = i_wdata;
        IPC_ADDR_SEL:   next_st.sel   = i_wdata;
        IPC_ADDR_CTRL:  next_st.ctrl  = i_wdata;
        IPC_ADDR_DELAY: next_st.delay = i_wdata;
        default: ;
      endcase
    end

    // reading the result acknowledges it; a new result wins the same cycle
    if (i_rd && i_addr == IPC_ADDR_RESULT) begin
      next_st.conversion_done_pin = 1'b0;
    end
    if (i_result_valid && !pd_eff) begin
      next_st.result = i_result;
      next_st.conversion_done_pin   = 1'b1;
    end

    // conversions stop before reconfiguring the excitation
    if (cmd_stop) begin
      next_st.cmd_run = 1'b0;
    end else if (cmd_start) begin
      next_st.cmd_run = 1'b1;
    end

    if (cmd_pdown) begin
      next_st.pd = 1'b1;
    end else if (cmd_wake) begin
      next_st.pd = 1'b0;
    end

    if (soft_rst) begin
      next_st.amp     = IPC_AMP_RST;
      next_st.sel     = IPC_SEL_RST;
      next_st.ctrl    = IPC_CTRL_RST;
      next_st.delay   = IPC_DELAY_RST;
      next_st.result  = 8'h00;
      next_st.conversion_done_pin    = 1'b0;
      next_st.cmd_run = 1'b0;
      next_st.pd      = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= IPC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  ipc_exc_if exc_bus ();

  assign exc_bus.run       = converting && st.ctrl[IPC_CTRL_EXC_EN];
  assign exc_bus.four_wire = st.ctrl[IPC_CTRL_FOUR];
  assign exc_bus.connect   = st.ctrl[IPC_CTRL_CONN];
  assign exc_bus.out_en    = st.ctrl[IPC_CTRL_OE] && !pd_eff;
  // delay is host programmed to cover input filter settling
  assign exc_bus.delay     = st.delay;

  ipc_excite #(
    .PHASE_CYCLES (PHASE_CYCLES)
  ) u_excite (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .exc       (exc_bus)
  );

  assign o_rdata            = st.rdata;
  assign o_amp_skip         = st.amp[IPC_AMP_SKIP_BIT];
  assign o_gain_code        = st.amp[IPC_GAIN_LSB +: 3];
  assign o_pos_input_select = st.sel[IPC_POS_LSB +: 4];
  assign o_neg_input_select = st.sel[IPC_NEG_LSB +: 4];
  assign o_use_int_osc      = st.clk_idle == IPC_CLK_IDLE_CYC;
  assign o_convert          = converting;
  assign o_power_down       = pd_eff;
  assign o_gpio             = exc_bus.gpio;
  assign o_gpio_oe          = exc_bus.gpio_oe;
  assign o_conversion_done_pin_n = !st.conversion_done_pin;

  // chip select held low simply leaves the pin driven all the time
  assign o_serial_out_done_oe  = !st.sync_cs[1];
  assign o_serial_out_done_pin = i_sdo_busy ? i_sdo_bit : !st.conversion_done_pin;

  a_amp_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !st.sync_rst[1] |=> st.amp == IPC_AMP_RST)
    else $error("amp register not at default after pin reset");
  a_sel_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    cmd_reset |=> (st.sel == IPC_SEL_RST && !o_convert))
    else $error("input select not at default after reset command");
  a_skip_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == IPC_ADDR_AMP && !soft_rst)
      |=> o_amp_skip == $past(i_wdata[7]))
    else $error("skip mode does not follow written bit");
  a_gain_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == IPC_ADDR_AMP && !soft_rst)
      |=> o_gain_code == $past(i_wdata[2:0]))
    else $error("gain code does not follow write");
  a_pos_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == IPC_ADDR_SEL && !soft_rst)
      |=> o_pos_input_select == $past(i_wdata[7:4]))
    else $error("positive selector does not follow write");
  a_neg_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == IPC_ADDR_SEL && !soft_rst)
      |=> o_neg_input_select == $past(i_wdata[3:0]))
    else $error("negative selector does not follow write");
  a_amp_readback: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == IPC_ADDR_AMP) |=> o_rdata == $past(st.amp))
    else $error("amp register read back wrong");
  a_sel_readback: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == IPC_ADDR_SEL) |=> o_rdata == $past(st.sel))
    else $error("input select read back wrong");
  a_rdata_idle: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data present without a read");
  a_int_osc: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!st.sync_clk[1] && !st.sync_clk[2]) [*8] |-> ##[0:70] o_use_int_osc)
    else $error("grounded clock pin did not select internal osc");
  a_osc_edge: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ext_edge |=> !o_use_int_osc)
    else $error("internal osc kept while clock pin toggles");
  a_free_run: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st.sync_start[1] && st.ctrl[IPC_CTRL_CONT] && !pd_eff) |-> o_convert)
    else $error("start pin high in continuous mode not converting");
  a_stop_cmd: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    cmd_stop |=> !st.cmd_run)
    else $error("stop command did not halt conversions");
  a_pd_pin: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $fell(i_power_down_pin_n) |-> ##2 (o_power_down && !o_convert))
    else $error("power-down pin not honoured two cycles later");
  a_sdo_release: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    st.sync_cs[1] |-> !o_serial_out_done_oe)
    else $error("combined pin driven while deselected");
  a_sdo_drive: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !st.sync_cs[1] |-> o_serial_out_done_oe)
    else $error("combined pin not driven while selected");
  a_conversion_done_pin_poll: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_result_valid && !pd_eff && !soft_rst)
      |=> (st.conversion_done_pin && !o_conversion_done_pin_n))
    else $error("data ready not raised on new result");
  a_conversion_done_pin_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == IPC_ADDR_RESULT && !i_result_valid) |=> !st.conversion_done_pin)
    else $error("data ready not cleared by result read");
  a_result_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_result_valid && !pd_eff && !soft_rst) |=> st.result == $past(i_result))
    else $error("result not buffered");
  a_result_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == IPC_ADDR_RESULT) |=> o_rdata == $past(st.result))
    else $error("buffered result read back wrong");
endmodule : ipc_input_path
`default_nettype wire

// file: hw/ipc_pkg.sv
// constants shared by the input path configuration block
package ipc_pkg;
  localparam int unsigned IPC_CLK_HZ = 40_000_000;

  localparam logic [7:0] IPC_ADDR_AMP    = 8'h10;
  localparam logic [7:0] IPC_ADDR_SEL    = 8'h11;
  localparam logic [7:0] IPC_ADDR_CTRL   = 8'h12;
  localparam logic [7:0] IPC_ADDR_STAT   = 8'h13;
  localparam logic [7:0] IPC_ADDR_RESULT = 8'h14;
  localparam logic [7:0] IPC_ADDR_DELAY  = 8'h15;

  localparam logic [7:0] IPC_AMP_RST   = 8'h00;
  localparam logic [7:0] IPC_SEL_RST   = 8'hff;
  localparam logic [7:0] IPC_CTRL_RST  = 8'h00;
  localparam logic [7:0] IPC_DELAY_RST = 8'h10;

  localparam int unsigned IPC_AMP_SKIP_BIT = 7;
  localparam int unsigned IPC_GAIN_LSB     = 0;
  localparam logic [2:0]  IPC_GAIN_1       = 3'h0;
  localparam logic [2:0]  IPC_GAIN_64      = 3'h6;
  localparam logic [2:0]  IPC_GAIN_128     = 3'h7;

  localparam int unsigned IPC_POS_LSB  = 4;
  localparam int unsigned IPC_NEG_LSB  = 0;
  localparam logic [3:0]  IPC_SEL_ANALOG_INPUT_0 = 4'h3;
  localparam logic [3:0]  IPC_SEL_ANALOG_INPUT_5 = 4'h8;
  localparam logic [3:0]  IPC_SEL_TEMP = 4'hb;
  localparam logic [3:0]  IPC_SEL_OPEN = 4'he;
  localparam logic [3:0]  IPC_SEL_COM  = 4'hf;

  localparam int unsigned IPC_CTRL_CONT   = 0;
  localparam int unsigned IPC_CTRL_EXC_EN = 1;
  localparam int unsigned IPC_CTRL_FOUR   = 2;
  localparam int unsigned IPC_CTRL_CONN   = 3;
  localparam int unsigned IPC_CTRL_OE     = 4;

  localparam int unsigned IPC_STAT_CONVERSION_DONE_PIN   = 0;
  localparam int unsigned IPC_STAT_CONV   = 1;
  localparam int unsigned IPC_STAT_PD     = 2;
  localparam int unsigned IPC_STAT_INTOSC = 3;
  localparam int unsigned IPC_STAT_SELBAD = 4;
  localparam int unsigned IPC_STAT_GAINBAD = 5;

  localparam logic [7:0] IPC_CLK_IDLE_CYC = 8'h40;

  typedef enum logic [2:0] {
    IPC_CMD_NONE  = 3'h0,
    IPC_CMD_START = 3'h1,
    IPC_CMD_STOP  = 3'h2,
    IPC_CMD_RESET = 3'h3,
    IPC_CMD_PDOWN = 3'h4,
    IPC_CMD_WAKE  = 3'h5
  } ipc_cmd_t;

  typedef enum logic [1:0] {
    IPC_EX_IDLE  = 2'b00,
    IPC_EX_DRV_A = 2'b01,
    IPC_EX_GAP   = 2'b11,
    IPC_EX_DRV_B = 2'b10
  } ipc_ex_state_t;
endpackage : ipc_pkg

// file: sim/ipc_host_model.sv
// host controller model: register bus master, commands and optional pins
`timescale 1ns/1ps
`default_nettype none
module ipc_host_model
  import ipc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic            o_cs_n,
  output logic            o_ext_clk,
  output logic            o_start,
  output logic            o_reset_pin_n,
  output logic            o_pd_n,
  output logic            o_cmd_valid,
  output logic      [2:0] o_cmd
);
  localparam logic [3:0] LEGAL [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                       4'h8, 4'hb, 4'he, 4'hf};
  logic ext_run;

  initial begin
    {o_addr, o_wdata, o_wr, o_rd, o_cmd_valid, o_cmd} = '0;
    o_cs_n        = 1'b0;
    o_start       = 1'b0;
    o_reset_pin_n = 1'b1;
    o_pd_n        = 1'b1;
    o_ext_clk     = 1'b0;
    ext_run       = 1'b1;
  end

  // grounded, not floating, once the external source stops
  always @(posedge i_clk) begin
    o_ext_clk <= ext_run ? ~o_ext_clk : 1'b0;
  end

  // only documented selector codes are ever programmed
  function automatic logic [3:0] pick_sel();
    return LEGAL[$urandom_range(0, 8)];
  endfunction : pick_sel

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= v;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~v;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    v = i_rdata;
  endtask : bus_rd

  task automatic amp_wr(input logic skip, input logic [2:0] g);
    bus_wr(IPC_ADDR_AMP, {skip, 4'h0, g});
  endtask : amp_wr

  task automatic send_cmd(input ipc_cmd_t c);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd       <= c;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd       <= ~c;
  endtask : send_cmd

  task automatic set_pins(input logic cs, st, rs, pd);
    @(posedge i_clk);
    o_cs_n        <= cs;
    o_start       <= st;
    o_reset_pin_n <= rs;
    o_pd_n        <= pd;
  endtask : set_pins

  // stop, set delay, set mode, connect, enable outputs, restart
  task automatic excite_setup(input logic four, input logic [7:0] dly);
    send_cmd(IPC_CMD_STOP);
    bus_wr(IPC_ADDR_DELAY, dly);
    bus_wr(IPC_ADDR_CTRL, {5'h00, four, 2'b10});
    bus_wr(IPC_ADDR_CTRL, {4'h0, 1'b1, four, 2'b10});
    bus_wr(IPC_ADDR_CTRL, {3'h0, 2'b11, four, 2'b10});
    send_cmd(IPC_CMD_START);
  endtask : excite_setup
endmodule : ipc_host_model
`default_nettype wire

// file: sim/test_ipc_input_path.sv
// self-checking bench for the input path configuration block
`timescale 1ns/1ps
`default_nettype none
`define IPC_CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module test_ipc_input_path
  import ipc_pkg::*;
();
  localparam int unsigned PH = 4;
  logic            clk, rst_n, res_vld, sdo_busy, sdo_bit;
  logic      [7:0] res, m_amp, m_sel, d, dly;
  wire logic [7:0] addr, wdata, rdata;
  wire logic       wr, rd, cs_n, ext_clk, start, rst_pin_n, pd_n, cmd_vld;
  wire logic       sod_pin, sod_oe, cdone_n, skip, osc, conv, pd;
  wire logic [2:0] cmd, gain;
  wire logic [3:0] pos, neg, gpio, gpio_oe;
  int              n_errors, cmp_count, n, res_q[$];
  logic      [2:0] glist [3] = '{IPC_GAIN_1, IPC_GAIN_64, IPC_GAIN_128};

  ipc_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_cs_n(cs_n),
    .o_ext_clk(ext_clk), .o_start(start), .o_reset_pin_n(rst_pin_n),
    .o_pd_n(pd_n), .o_cmd_valid(cmd_vld), .o_cmd(cmd));

  ipc_input_path #(.PHASE_CYCLES(PH)) uut (.i_clk(clk), .i_reset_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_cs_n(cs_n), .i_ext_clock_input(ext_clk), .i_start(start),
    .i_reset_pin_n(rst_pin_n), .i_power_down_pin_n(pd_n),
    .i_cmd_valid(cmd_vld), .i_cmd(cmd), .i_result_valid(res_vld),
    .i_result(res), .i_sdo_busy(sdo_busy), .i_sdo_bit(sdo_bit),
    .o_serial_out_done_pin(sod_pin), .o_serial_out_done_oe(sod_oe),
    .o_conversion_done_pin_n(cdone_n), .o_amp_skip(skip),
    .o_gain_code(gain), .o_pos_input_select(pos),
    .o_neg_input_select(neg), .o_use_int_osc(osc), .o_convert(conv),
    .o_power_down(pd), .o_gpio(gpio), .o_gpio_oe(gpio_oe));

  always #12.5 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.bus_rd(a, d);
    `IPC_CHK(d, e)
  endtask : rd_chk

  task automatic push_result(input bit keep);
    logic [7:0] v;
    v = 8'($urandom);
    @(posedge clk);
    res_vld <= 1'b1;
    res     <= v;
    @(posedge clk);
    res_vld <= 1'b0;
    res     <= ~v;
    #1;
    if (keep) res_q.push_back(v);
  endtask : push_result

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cycles

  // bounded poll; a stuck driver ends the run rather than hanging it
  task automatic wait_gpio(input logic [3:0] v);
    int k;
    k = 0;
    #1;
    while (gpio !== v && k < 400) begin
      cycles(1);
      k++;
    end
    if (k >= 400) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_gpio

  task automatic run_len(input logic [3:0] v, output int k);
    k = 0;
    while (gpio === v && k < 300) begin
      cycles(1);
      k++;
    end
    if (k >= 300) begin
      n_errors++;
      give_verdict();
    end
  endtask : run_len

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(55));
    {clk, rst_n, res_vld, res, sdo_busy, sdo_bit} = '0;
    m_amp = IPC_AMP_RST;
    m_sel = IPC_SEL_RST;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cycles(1);
    `IPC_CHK({pos, neg}, m_sel)
    `IPC_CHK({skip, gain}, 4'h0)
    rd_chk(IPC_ADDR_AMP, m_amp);
    rd_chk(IPC_ADDR_SEL, m_sel);
    rd_chk(8'h20, 8'h00);
    for (int i = 0; i < 6; i++) begin
      m_amp = {i > 2, 4'h0, glist[i % 3]};
      host.amp_wr(m_amp[7], m_amp[2:0]);
      #1;
      `IPC_CHK(skip, m_amp[7])
      `IPC_CHK(gain, m_amp[2:0])
      rd_chk(IPC_ADDR_AMP, m_amp);
    end
    for (int i = 0; i < 8; i++) begin
      m_sel = {host.pick_sel(), host.pick_sel()};
      host.bus_wr(IPC_ADDR_SEL, m_sel);
      #1;
      `IPC_CHK(pos, m_sel[7:4])
      `IPC_CHK(neg, m_sel[3:0])
      rd_chk(IPC_ADDR_SEL, m_sel);
    end
    push_result(1);
    push_result(1);
    `IPC_CHK(cdone_n, 1'b0)
    `IPC_CHK(sod_pin, 1'b0)
    host.bus_rd(IPC_ADDR_STAT, d);
    `IPC_CHK(d[IPC_STAT_CONVERSION_DONE_PIN], 1'b1)
    host.bus_rd(IPC_ADDR_RESULT, d);
    `IPC_CHK(d, 8'(res_q[$]))
    `IPC_CHK(cdone_n, 1'b1)
    res_q.delete();
    `IPC_CHK(sod_oe, 1'b1)
    @(posedge clk);
    sdo_busy <= 1'b1;
    sdo_bit  <= 1'b0;
    #1;
    `IPC_CHK(sod_pin, 1'b0)
    @(posedge clk);
    sdo_busy <= 1'b0;
    host.set_pins(1, 0, 1, 1);
    cycles(4);
    `IPC_CHK(sod_oe, 1'b0)
    host.send_cmd(IPC_CMD_START);
    #1;
    `IPC_CHK(conv, 1'b1)
    host.send_cmd(IPC_CMD_STOP);
    #1;
    `IPC_CHK(conv, 1'b0)
    host.bus_wr(IPC_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      host.set_pins(0, i == 0, 1, 1);
      cycles(4);
      `IPC_CHK(conv, i == 0)
    end
    host.set_pins(0, 0, 1, 0);
    cycles(4);
    `IPC_CHK(pd, 1'b1)
    push_result(0);
    `IPC_CHK(cdone_n, 1'b1)
    host.set_pins(0, 0, 1, 1);
    cycles(4);
    `IPC_CHK(pd, 1'b0)
    host.send_cmd(IPC_CMD_PDOWN);
    #1;
    `IPC_CHK(pd, 1'b1)
    host.send_cmd(IPC_CMD_WAKE);
    #1;
    `IPC_CHK(pd, 1'b0)
    `IPC_CHK(osc, 1'b0)
    host.ext_run = 1'b0;
    cycles(50);
    `IPC_CHK(osc, 1'b0)
    n = 0;
    while (osc !== 1'b1 && n < 40) begin
      cycles(1);
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      give_verdict();
    end
    `IPC_CHK(osc, 1'b1)
    for (int f = 1; f >= 0; f--) begin
      dly = 8'(1 + $urandom_range(0, 3));
      host.excite_setup(f[0], dly);
      wait_gpio(f ? 4'h5 : 4'h1);
      `IPC_CHK(gpio_oe, 4'hf)
      run_len(gpio, n);
      `IPC_CHK(n, int'(PH))
      run_len(4'h0, n);
      `IPC_CHK(n, int'(dly) + 1)
      `IPC_CHK(gpio, f ? 4'ha : 4'h2)
      host.send_cmd(IPC_CMD_PDOWN);
      #1;
      `IPC_CHK(gpio_oe, 4'h0)
      host.send_cmd(IPC_CMD_WAKE);
    end
    host.amp_wr(1'b1, IPC_GAIN_64);
    host.send_cmd(IPC_CMD_RESET);
    #1;
    `IPC_CHK({skip, gain}, 4'h0)
    rd_chk(IPC_ADDR_SEL, IPC_SEL_RST);
    host.set_pins(0, 0, 0, 1);
    cycles(4);
    host.amp_wr(1'b1, IPC_GAIN_128);
    #1;
    `IPC_CHK({skip, gain}, 4'h0)
    host.set_pins(0, 0, 1, 1);
    cycles(4);
    rd_chk(IPC_ADDR_AMP, IPC_AMP_RST);
    give_verdict();
  end
endmodule : test_ipc_input_path
`default_nettype wire
